// [rtl/health_word_builder.sv]
// Purpose: builds the 16-bit health word and paces packet output
// Assumes: apb slave on mclk, fault sources are asynchronous pins
// Notes:   filter math and diagnostic packet contents live elsewhere
//
// Behaviour
// - two-byte health word with every packet
// - low byte errors, high byte alerts
// - bit 0 flags fatal failure
// - bit 1 flags internal hardware error
// - bit 2 flags communication error
// - bit 3 software error or alignment bad
// - uncalibrated magnetics raise software error
// - bit 8 ORs all enabled alerts
// - bit 10 flags lost positioning link
// - bit 11 during init or high gain
// - bit 12 while sensor over range
// - per-category alert enables set by host
// - optional turn detection raises algorithm alert
// - get-packet request yields diagnostic packet
// - fixed 100 Hz internal update tick
// - selectable packet rate or polled only
// - sixty second init phase, then low gain
// - navigation variant reports missing acquisition on bit 9
// - align update ticks to utc second
// - restart setting picks over-range handling
`timescale 1ns/1ps
`default_nettype none
`include "health_word_regs.svh"

module health_word_builder #(
    parameter int unsigned TICK_CYCLES = `CLK_HZ / `UPDATE_HZ,
    parameter int unsigned INIT_TICKS  = `INIT_SECONDS * `UPDATE_HZ
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // asynchronous fault and status sources
    input  wire logic        hwFaultIn,
    input  wire logic        linkFaultIn,
    input  wire logic        swFaultIn,
    input  wire logic        magUncalibrated,
    input  wire logic        magneticAlignmentBad,
    input  wire logic        rateOverflowIn,
    input  wire logic        positioningLinkLost,
    input  wire logic        positioningAcquired,
    input  wire logic        highGainIn,
    input  wire logic        utcSecondPulse,
    // yaw rate magnitude, 0.01 deg/s units, same clock
    input  wire logic [15:0] yawRateAbs,
    input  wire logic [15:0] maxRateAbs,
    input  wire logic        getPacketRequest,
    // packet side
    output logic      [15:0] healthWord,
    output logic             updateTick,
    output logic             packetStrobe,
    output logic             diagnosticPacket,
    output logic             highGain
);
    import health_word_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // full-period tick counts per rate code, zero means polled
    function automatic logic [6:0] ticksPerPacket(input rate_e r);
        unique case (r)
            RATE_QUIET: ticksPerPacket = 7'd0;
            RATE_100:   ticksPerPacket = 7'd1;
            RATE_50:    ticksPerPacket = 7'd2;
            RATE_25:    ticksPerPacket = 7'd4;
            RATE_20:    ticksPerPacket = 7'd5;
            RATE_10:    ticksPerPacket = 7'd10;
            RATE_5:     ticksPerPacket = 7'd20;
            RATE_2:     ticksPerPacket = 7'd50;
        endcase
    endfunction : ticksPerPacket

    // word-aligned address match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops each

    // top bit of the bank is the utc pulse, edge detected below
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] syncA_q;          // first stage, read only by stage 2
    logic [NSYNC-1:0] syncB_q;          // safe to use
    logic             utcPrev_q;        // edge detect on stage 2

    // all pins sampled together
    always_ff @(posedge mclk) begin
        if (reset) begin
            syncA_q <= '0;
            syncB_q <= '0;
            utcPrev_q <= 1'b0;
        end else if (clkEn) begin
            syncA_q <= {utcSecondPulse, highGainIn, positioningAcquired,
                        positioningLinkLost, rateOverflowIn,
                        magneticAlignmentBad, magUncalibrated, swFaultIn,
                        linkFaultIn, hwFaultIn};
            syncB_q <= syncA_q;
            utcPrev_q <= syncB_q[9];
        end
    end

    logic sHwFault, sLinkFault, sSwFault, sMagUncal, sAlignBad;
    logic sOverflow, sLinkLost, sAcquired, sHighGain, utcEdge;
    assign sHwFault   = syncB_q[0];
    assign sLinkFault = syncB_q[1];
    assign sSwFault   = syncB_q[2];
    assign sMagUncal  = syncB_q[3];
    assign sAlignBad  = syncB_q[4];
    assign sOverflow  = syncB_q[5];
    assign sLinkLost  = syncB_q[6];
    assign sAcquired  = syncB_q[7];
    assign sHighGain  = syncB_q[8];
    assign utcEdge    = syncB_q[9] & ~utcPrev_q;

    ////////////////////////////////////////////////////////////////////////
    // apb register file

    logic [31:0] ctrl_q;               // enables, modes, rate
    logic [15:0] thresh_q;             // turn threshold
    logic        apbAccess;
    logic        apbMapped;

    assign apbAccess = psel & penable;
    // anything outside the five words is refused with pslverr
    assign apbMapped = hit(paddr, `OFS_CTRL) | hit(paddr, `OFS_THRESH)
                     | hit(paddr, `OFS_WORD) | hit(paddr, `OFS_STATUS)
                     | hit(paddr, `OFS_SOURCES);

    // host sets which categories and modes apply
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q   <= `CTRL_RESET_VAL;
            thresh_q <= `TURN_THRESH_RST;
        end else if (clkEn && apbAccess && pwrite && pready) begin
            if (hit(paddr, `OFS_CTRL)) begin
                ctrl_q <= pwdata;
            end
            if (hit(paddr, `OFS_THRESH)) begin
                thresh_q <= pwdata[15:0];
            end
        end
    end

    logic enHw, enSw, enSensor, enLink, turnEn, restartSet, navVariant;
    rate_e rateSel;
    assign enHw       = ctrl_q[`CTRL_EN_HW];
    assign enSw       = ctrl_q[`CTRL_EN_SW];
    assign enSensor   = ctrl_q[`CTRL_EN_SENSOR];
    assign enLink     = ctrl_q[`CTRL_EN_LINK];
    assign turnEn     = ctrl_q[`CTRL_TURN_EN];
    assign restartSet = ctrl_q[`CTRL_RESTART];
    assign navVariant = ctrl_q[`CTRL_NAV];
    assign rateSel    = rate_e'(ctrl_q[`CTRL_RATE_LO +: `CTRL_RATE_W]);

    ////////////////////////////////////////////////////////////////////////
    // 100 hz tick, aligned to utc second

    logic [31:0] tickCnt_q;            // cycles within one update
    logic [6:0]  secTicks_q;           // ticks within one second
    logic        tick;

    // tick marks the last cycle of each update period
    assign tick = (tickCnt_q == TICK_CYCLES - 1);

    // utc edge restarts the period so sampling lands on the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            tickCnt_q  <= '0;
            secTicks_q <= '0;
        end else if (clkEn) begin
            if (utcEdge) begin
                tickCnt_q  <= '0;
                secTicks_q <= '0;
            end else if (tick) begin
                tickCnt_q  <= '0;
                secTicks_q <= (secTicks_q == `SEC_PER_UPDATE - 7'd1)
                              ? 7'd0 : secTicks_q + 7'd1;
            end else begin
                tickCnt_q <= tickCnt_q + 32'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // algorithm phase: init, run, halted on over-range

    alg_e        alg_q;
    logic [31:0] initCnt_q;            // ticks spent initialising
    logic        quiet;

    // quasi-static test on the largest low-passed rate magnitude
    assign quiet = (maxRateAbs < `QUIET_RATE);

    // init runs sixty seconds at high gain, then drops to low gain
    always_ff @(posedge mclk) begin
        if (reset) begin
            alg_q     <= ALG_INIT;
            initCnt_q <= '0;
        end else if (clkEn) begin
            unique case (alg_q)
                ALG_INIT: begin
                    if (sOverflow && restartSet) begin
                        alg_q <= ALG_HALTED;
                    end else if (tick) begin
                        if (initCnt_q == INIT_TICKS - 1) begin
                            alg_q <= ALG_RUN;
                        end
                        initCnt_q <= initCnt_q + 32'd1;
                    end
                end
                ALG_RUN: begin
                    if (sOverflow && restartSet) begin
                        alg_q <= ALG_HALTED;
                    end
                end
                ALG_HALTED: begin
                    // wait for quasi-static before restarting
                    if (!sOverflow && quiet) begin
                        alg_q     <= ALG_INIT;
                        initCnt_q <= '0;
                    end
                end
                default: alg_q <= ALG_INIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // health word assembly

    logic [15:0] word;
    logic        hwAlertSrc, algAlertSrc;
    logic        turning;

    assign turning     = turnEn && (yawRateAbs > thresh_q);
    // navigation variant reports missing acquisition on hardware bit
    assign hwAlertSrc  = navVariant & ~sAcquired;
    assign algAlertSrc = (alg_q == ALG_INIT) | sHighGain
                       | turning;

    // one word, reserved positions stay zero
    always_comb begin
        word = 16'h0000;
        word[`HW_FATAL]      = (alg_q == ALG_HALTED);
        word[`HW_HWERR]      = sHwFault;
        word[`HW_LINKERR]    = sLinkFault;
        word[`HW_SWERR]      = sSwFault | sAlignBad
                             | sMagUncal;
        word[`HW_HWALERT]    = enHw & hwAlertSrc;
        word[`HW_LINKALERT]  = enLink & sLinkLost;
        word[`HW_ALGALERT]   = enSw & algAlertSrc;
        word[`HW_RANGEALERT] = enSensor & sOverflow
                             & ~restartSet;
        word[`HW_SUMMARY]    = word[`HW_HWALERT] | word[`HW_LINKALERT]
                             | word[`HW_ALGALERT]
                             | word[`HW_RANGEALERT];
    end

    ////////////////////////////////////////////////////////////////////////
    // packet pacing

    logic [6:0] pktCnt_q;              // ticks since last periodic packet
    logic [6:0] period;

    assign period = ticksPerPacket(rateSel);

    // one strobe per chosen period; polled mode only on request
    always_ff @(posedge mclk) begin
        if (reset) begin
            pktCnt_q         <= '0;
            packetStrobe     <= 1'b0;
            diagnosticPacket <= 1'b0;
            updateTick       <= 1'b0;
            healthWord       <= '0;
            highGain         <= 1'b1;
        end else if (clkEn) begin
            updateTick       <= tick;
            packetStrobe     <= 1'b0;
            diagnosticPacket <= 1'b0;
            highGain         <= (alg_q != ALG_RUN);
            // a request takes the slot; a periodic strobe due now waits for the next tick
            if (getPacketRequest) begin
                diagnosticPacket <= 1'b1;
                packetStrobe     <= 1'b1;
                healthWord       <= word;
            end else if (tick && period != 7'd0) begin
                if (pktCnt_q >= period - 7'd1) begin
                    pktCnt_q     <= '0;
                    packetStrobe <= 1'b1;
                    healthWord   <= word;
                end else begin
                    pktCnt_q <= pktCnt_q + 7'd1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer, one wait-free access phase

    // reads give live word and phase; unmapped addresses error
    // read data is latched in setup so it stands through the access
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~apbMapped;
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                if (hit(paddr, `OFS_CTRL)) begin
                    prdata <= ctrl_q;
                end else if (hit(paddr, `OFS_THRESH)) begin
                    prdata <= {16'h0000, thresh_q};
                end else if (hit(paddr, `OFS_WORD)) begin
                    prdata <= {16'h0000, word};
                end else if (hit(paddr, `OFS_STATUS)) begin
                    prdata <= {23'h0, secTicks_q, alg_q};
                end else if (hit(paddr, `OFS_SOURCES)) begin
                    prdata <= {22'h0, syncB_q};
                end
            end
        end
    end
endmodule : health_word_builder
`default_nettype wire

// [rtl/health_word_pkg.sv]
// Purpose: types shared by the health word builder
// Assumes: nothing
// Notes:   output rate codes and restart states
`default_nettype none
package health_word_pkg;
    // packet output rate selection
    typedef enum logic [2:0] {
        RATE_QUIET = 3'b000,
        RATE_100   = 3'b001,
        RATE_50    = 3'b010,
        RATE_25    = 3'b011,
        RATE_20    = 3'b100,
        RATE_10    = 3'b101,
        RATE_5     = 3'b110,
        RATE_2     = 3'b111
    } rate_e;

    // algorithm phase
    typedef enum logic [1:0] {
        ALG_INIT   = 2'b00,
        ALG_RUN    = 2'b01,
        ALG_HALTED = 2'b10
    } alg_e;
endpackage : health_word_pkg
`default_nettype wire

// [rtl/health_word_regs.svh]
// Purpose: register map, field positions and timing constants
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes:   definitions only
`ifndef HEALTH_WORD_REGS_SVH
`define HEALTH_WORD_REGS_SVH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_THRESH      12'h004
`define OFS_WORD        12'h008
`define OFS_STATUS      12'h00c
`define OFS_SOURCES     12'h010

// control register fields
`define CTRL_EN_HW      0
`define CTRL_EN_SW      1
`define CTRL_EN_SENSOR  2
`define CTRL_EN_LINK    3
`define CTRL_TURN_EN    4
`define CTRL_RESTART    5
`define CTRL_NAV        6
`define CTRL_RATE_LO    8
`define CTRL_RATE_W     3
`define CTRL_RESET_VAL  32'h0000_020f

// health word bit positions
`define HW_FATAL        0
`define HW_HWERR        1
`define HW_LINKERR      2
`define HW_SWERR        3
`define HW_SUMMARY      8
`define HW_HWALERT      9
`define HW_LINKALERT    10
`define HW_ALGALERT     11
`define HW_RANGEALERT   12

// turn threshold in 0.01 deg/s units, 0.5 deg/s
`define TURN_THRESH_RST 16'h0032
// quasi-static restart limit, 3 deg/s in 0.01 deg/s units
`define QUIET_RATE      16'h012c

// timing figures
`define CLK_HZ          100_000_000
`define UPDATE_HZ       100
`define INIT_SECONDS    60
`define SEC_PER_UPDATE  7'd100

`endif

// [sim/health_word_builder_bench.sv]
// Purpose: directed bench for the health word builder
// Assumes: short tick and init parameters
// Notes:   word read live over apb, packets counted by host model
`timescale 1ns/1ps
`default_nettype none
module health_word_builder_bench;
    localparam int TICKS = 10;
    logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, getPacketRequest = 1'b0, pready, pslverr, e;
    logic updateTick, packetStrobe, diagnosticPacket, highGain;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] healthWord, yawRateAbs = 16'h0, maxRateAbs = 16'h0;
    logic [15:0] pktCount, diagCount, lastWord, p0, d0;
    // hw link sw mag align lost ovf acquired highgain
    logic [8:0]  faults = 9'h000;
    logic [15:0] expTab [7] = '{16'h2, 16'h4, 16'h8, 16'h8, 16'h8, 16'h500, 16'h1100};
    int          kTab [8] = '{0, 1, 2, 4, 5, 10, 20, 50}; // ticks per packet
    int          errTotal = 0, comparisons = 0;
    int          utcWait = 0;     // edges from utc restart to next tick
    logic        utcPulse = 1'b0; // utc second pin
    always #5 mclk = ~mclk;
    health_word_builder #(.TICK_CYCLES(TICKS), .INIT_TICKS(3)) health_word_builder_i (
        .mclk, .reset, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hwFaultIn(faults[0]),
        .linkFaultIn(faults[1]), .swFaultIn(faults[2]), .magUncalibrated(faults[3]),
        .magneticAlignmentBad(faults[4]), .positioningLinkLost(faults[5]),
        .rateOverflowIn(faults[6]), .positioningAcquired(faults[7]),
        .highGainIn(faults[8]), .utcSecondPulse(utcPulse), .yawRateAbs,
        .maxRateAbs,
        .getPacketRequest, .healthWord, .updateTick, .packetStrobe,
        .diagnosticPacket, .highGain);
    host_packet_sink host_packet_sink_i (.mclk, .reset, .packetStrobe,
        .diagnosticPacket, .healthWord, .pktCount_q(pktCount),
        .diagCount_q(diagCount), .lastWord_q(lastWord));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no wait limit here; the watchdog ends a hung access
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask : rd
    // sources pass a two-flop sync, so allow settling
    task automatic setf(input logic [8:0] f);
        @(posedge mclk);
        faults <= f;
        repeat (6) @(posedge mclk);
    endtask : setf
    task automatic waitStrobe();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (packetStrobe !== 1'b1 && n < 600);
        if (n == 600) errTotal++;
    endtask : waitStrobe
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errTotal, comparisons);
        if (errTotal == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    // hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(12'h000, 32'hffffffff, 32'h20f);
        rd(12'h004, 32'hffff, 32'h32);
        rd(12'h008, 32'hffff, 32'h900);
        rd(12'h00c, 32'h3, 32'h0);
        chk(highGain, 1'b1);
        repeat (50) @(posedge mclk);
        rd(12'h00c, 32'h3, 32'h1);
        chk(highGain, 1'b0);
        rd(12'h008, 32'hffff, 32'h0);
        xfer(1'b0, 12'h014, 32'h0);
        chk({r[30:0], e}, 32'h1);
        // hw through ovf sources alone, error byte and alert byte
        for (int i = 0; i < 7; i++) begin
            setf(9'h001 << i);
            rd(12'h008, 32'hffff, expTab[i]);
        end
        xfer(1'b1, 12'h000, 32'h207);
        setf(9'h020);
        rd(12'h008, 32'h100, 32'h0);
        xfer(1'b1, 12'h000, 32'h24f);
        setf(9'h000);
        rd(12'h008, 32'hffff, 32'h300);
        setf(9'h080);
        rd(12'h008, 32'hffff, 32'h0);
        // turn threshold: equal stays quiet, one above alerts
        xfer(1'b1, 12'h000, 32'h21f);
        yawRateAbs <= 16'h0032;
        setf(9'h000);
        rd(12'h008, 32'hffff, 32'h0);
        yawRateAbs <= 16'h0033;
        setf(9'h000);
        rd(12'h008, 32'hffff, 32'h900);
        yawRateAbs <= 16'h0000;
        setf(9'h100);
        rd(12'h008, 32'hffff, 32'h900);
        // overflow with restart on holds fatal until quiet
        xfer(1'b1, 12'h000, 32'h22f);
        maxRateAbs <= 16'h0200;
        setf(9'h040);
        rd(12'h008, 32'h1001, 32'h1);
        setf(9'h000);
        rd(12'h008, 32'h1001, 32'h1);
        maxRateAbs <= 16'h0100;
        repeat (12) @(posedge mclk);
        rd(12'h008, 32'h1, 32'h0);
        rd(12'h00c, 32'h3, 32'h0);
        repeat (50) @(posedge mclk);
        // every periodic rate code (1 to 7): two packets per two periods
        for (int c = 1; c < 8; c++) begin
            xfer(1'b1, 12'h000, 32'h0f | (c << 8));
            waitStrobe();
            p0 = pktCount;
            repeat (2 * kTab[c] * TICKS) @(posedge mclk);
            chk(pktCount - p0, 32'h2);
        end
        // utc second edge restarts the tick period and second count
        @(posedge mclk);
        utcPulse <= 1'b1;
        @(posedge mclk);
        utcPulse <= 1'b0;
        repeat (3) @(posedge mclk);
        utcWait = 0;
        do begin
            @(posedge mclk);
            utcWait++;
        end while (updateTick !== 1'b1);
        chk(utcWait, TICKS);
        rd(12'h00c, 32'h1fc, 32'h4);
        xfer(1'b1, 12'h000, 32'h00f);
        repeat (20) @(posedge mclk);
        p0 = pktCount;
        d0 = diagCount;
        repeat (600) @(posedge mclk);
        chk(pktCount - p0, 32'h0);
        // a link fault gives the polled packet a word to carry
        setf(9'h002);
        getPacketRequest <= 1'b1;
        @(posedge mclk);
        getPacketRequest <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(diagCount - d0, 32'h1);
        chk(pktCount - p0, 32'h1);
        chk(lastWord, 32'h4);
        complete_run();
    end
endmodule : health_word_builder_bench
`default_nettype wire

// [sim/health_word_checker_assertions.sv]
// Purpose: port checks for the health word builder
// Assumes: clkEn held high by the bench
// Notes:   bound to the design top below
`timescale 1ns/1ps
`default_nettype none
module health_word_checker #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        getPacketRequest,
    input  wire logic        utcSecondPulse,
    input  wire logic [15:0] healthWord,
    input  wire logic        updateTick,
    input  wire logic        packetStrobe,
    input  wire logic        diagnosticPacket
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [15:0] tickGap_q;  // enabled edges since last tick
    logic        tickSeen_q; // first tick after reset has no gap
    logic [1:0]  utcHist_q;  // utc pin seen at the last two edges
    // utc pin history; the block restarts its period two edges later
    always_ff @(posedge mclk) begin
        if (reset) begin
            utcHist_q <= 2'b00;
        end else if (clkEn) begin
            utcHist_q <= {utcHist_q[0], utcSecondPulse};
        end
    end
    // tick spacing counter; phase unknown until one tick seen
    always_ff @(posedge mclk) begin
        if (reset) begin
            tickGap_q  <= 16'h0000;
            tickSeen_q <= 1'b0;
        end else if (clkEn && (utcSecondPulse || utcHist_q != 2'b00)) begin
            tickGap_q  <= 16'h0000; // gap after a utc restart is short
            tickSeen_q <= 1'b0;
        end else if (clkEn && updateTick) begin
            tickGap_q  <= 16'h0000;
            tickSeen_q <= 1'b1;
        end else if (clkEn) begin
            tickGap_q <= tickGap_q + 16'h0001;
        end
    end
    ////////////////////////////////////////
    a_tick_period: assert property (updateTick && tickSeen_q |-> tickGap_q == TICK_CYCLES - 1) else $error("tick spacing wrong");
    a_reserved_bits_zero: assert property (healthWord[7:4] == 4'h0 && healthWord[15:13] == 3'h0) else $error("reserved bit set");
    a_word_on_strobe: assert property ($changed(healthWord) |-> packetStrobe) else $error("word moved without packet");
    a_request_gives_packet: assert property (getPacketRequest |=> packetStrobe && diagnosticPacket) else $error("request not answered");
    a_diag_has_cause: assert property (diagnosticPacket |-> packetStrobe && $past(getPacketRequest)) else $error("stray diagnostic packet");
    a_summary_cause: assert property (healthWord[12:9] == 4'h0 |-> !healthWord[8]) else $error("summary without alert");
    a_fatal_not_range: assert property (healthWord[0] |-> !healthWord[12]) else $error("fatal and range together");
    a_access_ready: assert property (psel && penable |-> pready) else $error("access without ready");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel) && !$past(penable)) else $error("ready outside access");
    a_refuse_zero_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("refusal with data");
endmodule : health_word_checker
bind health_word_builder health_word_checker #(.TICK_CYCLES(TICK_CYCLES))
    health_word_checker_i (.mclk, .reset, .clkEn, .psel, .penable, .prdata,
    .pready, .pslverr, .getPacketRequest, .utcSecondPulse, .healthWord,
    .updateTick, .packetStrobe, .diagnosticPacket);
`default_nettype wire

// [sim/host_packet_sink.sv]
// Purpose: host model that takes measurement packets
// Assumes: one packet per packetStrobe
// Notes:   counts packets and keeps the last word seen
`timescale 1ns/1ps
`default_nettype none
module host_packet_sink (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        packetStrobe,
    input  wire logic        diagnosticPacket,
    input  wire logic [15:0] healthWord,
    output logic      [15:0] pktCount_q,
    output logic      [15:0] diagCount_q,
    output logic      [15:0] lastWord_q
);
    // take each packet with the word riding on it
    always_ff @(posedge mclk) begin
        if (reset) begin
            pktCount_q  <= 16'h0000;
            diagCount_q <= 16'h0000;
            lastWord_q  <= 16'h0000;
        end else if (packetStrobe) begin
            pktCount_q <= pktCount_q + 16'h0001;
            lastWord_q <= healthWord;
            if (diagnosticPacket) begin
                diagCount_q <= diagCount_q + 16'h0001;
            end
        end
    end
endmodule : host_packet_sink
`default_nettype wire
